// >>> core/rtc_cfg.svh
// Offsets, field positions, reset values and divider figures of the clock
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define RTC_A_ALM_BASE 5'h08
`define RTC_A_STATUS   5'h10
`define RTC_A_CMD      5'h11

// ----------------------------------------------------------------------
// Counter word indices
// ----------------------------------------------------------------------
`define RTC_IX_HUND 3'h0
`define RTC_IX_HOUR 3'h1
`define RTC_IX_MIN  3'h2
`define RTC_IX_SEC  3'h3
`define RTC_IX_MON  3'h4
`define RTC_IX_DATE 3'h5
`define RTC_IX_YEAR 3'h6
`define RTC_IX_DOW  3'h7

// ----------------------------------------------------------------------
// Command fields, alarm ignore bit, flag positions
// ----------------------------------------------------------------------
`define RTC_CMD_TEST 5
`define RTC_CMD_IEN  4
`define RTC_CMD_RUN  3
`define RTC_CMD_H24  2
`define RTC_ALM_IGN  7
`define RTC_FL_ALARM 0
`define RTC_FL_HUND  1
`define RTC_FL_TENTH 2
`define RTC_FL_SEC   3
`define RTC_FL_MIN   4
`define RTC_FL_HOUR  5
`define RTC_FL_DAY   6
`define RTC_FL_GLOB  7

// ----------------------------------------------------------------------
// Reset values and rates
// ----------------------------------------------------------------------
`define RTC_RST_CMD   6'h00
`define RTC_RST_MASK  7'h00
`define RTC_RST_FLAGS 8'h00
`define RTC_RST_WORD  8'h00
`define RTC_F_MID     4000
`define RTC_F_TICK    100
`define RTC_F_XT0     23'h00_8000
`define RTC_F_XT1     23'h10_0000
`define RTC_F_XT2     23'h20_0000
`define RTC_F_XT3     23'h40_0000

`endif

// >>> core/rtc_pkg.sv
// Types shared by the clock core and its helpers
package rtc_pkg;

  // Pins as they arrive, grouped for one synchroniser
  typedef struct packed {
    logic       xtal;
    logic       pwr_fail;
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [4:0] addr;
    logic [7:0] din;
  } rtc_pins_t;

  // Prescaler state
  typedef struct packed {
    logic        xtal_prev;
    logic [22:0] acc;
    logic [5:0]  cnt;
    logic        p4000;
    logic        p100;
  } rtc_pre_t;

  // Core state
  typedef struct packed {
    logic [7:0][7:0] tm;
    logic [7:0][7:0] alm;
    logic [5:0]      cmd;
    logic [6:0]      mask;
    logic [7:0]      flags;
    logic            irq;
    logic            acc_rd;
    logic            acc_wr;
    logic            rd_stat;
    logic            tick;
    logic [7:0]      dout;
  } rtc_state_t;

endpackage : rtc_pkg

// >>> core/rtc_sync.sv
// Two-stage synchroniser for a group of pins
`timescale 1ns/1ps
`default_nettype none

module rtc_sync #(
  parameter int          W   = 8,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [1:0][W-1:0] s_q;
  logic [1:0][W-1:0] s_d;

  if (W < 1)
  begin : g_bad_w
    $error("rtc_sync: width must be positive");
  end

  // First stage feeds only the second
  always_comb
  begin
    s_d = {s_q[0], d};
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      s_q <= {RST, RST};
    else
      s_q <= s_d;
  end

  assign q = s_q[1];

endmodule : rtc_sync

`default_nettype wire

// >>> core/rtc_prescaler.sv
// Crystal divider: fractional step to 4000Hz, then whole divide to 100Hz
`timescale 1ns/1ps
`default_nettype none
`include "rtc_cfg.svh"

module rtc_prescaler
  import rtc_pkg::*;
#(
  parameter int RATIO = `RTC_F_MID / `RTC_F_TICK
) (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       xtal,
  input  wire logic [1:0] fsel,
  input  wire logic       test,
  output logic            p4000,
  output logic            p100
);

  localparam logic [22:0] STEP = 23'(`RTC_F_MID);

  rtc_pre_t s_q;
  rtc_pre_t s_d;
  logic     xt_edge;
  logic [22:0] sum;

  if (RATIO < 2 || RATIO > 63)
  begin : g_bad_ratio
    $error("rtc_prescaler: ratio out of counter range");
  end

  // Crystal rate for the selected setting
  function automatic logic [22:0] xt_rate(input logic [1:0] sel);
    unique case (sel)
      2'b00: xt_rate = `RTC_F_XT0;
      2'b01: xt_rate = `RTC_F_XT1;
      2'b10: xt_rate = `RTC_F_XT2;
      2'b11: xt_rate = `RTC_F_XT3;
    endcase
  endfunction : xt_rate

  // Phase accumulator keeps the long-run rate exact; jitter is the cost
  always_comb
  begin
    s_d     = s_q;
    xt_edge = xtal && !s_q.xtal_prev;
    sum     = s_q.acc + STEP;
    s_d.xtal_prev = xtal;
    s_d.p4000 = 1'b0;
    s_d.p100  = 1'b0;
    if (xt_edge)
    begin
      if (sum >= xt_rate(fsel))
      begin
        s_d.acc   = sum - xt_rate(fsel);
        s_d.p4000 = 1'b1;
      end
      else
        s_d.acc = sum;
    end
    if (s_d.p4000)
    begin
      if (s_q.cnt == 6'(RATIO - 1))
      begin
        s_d.cnt  = 6'h00;
        s_d.p100 = 1'b1;
      end
      else
        s_d.cnt = s_q.cnt + 6'h01;
    end
    // Test mode drives the tick straight from the crystal
    if (test)
      s_d.p100 = xt_edge;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign p4000 = s_q.p4000;
  assign p100  = s_q.p100;

  AST_TICK_ON_MID: assert property (@(posedge mclk) disable iff (!nrst)
    (p100 && !test) |-> p4000 && s_q.cnt == 6'h00)
    else $error("100Hz tick without a 4000Hz step");

endmodule : rtc_prescaler

`default_nettype wire

// >>> core/rtc_core.sv
// Real-time clock core: counters, alarm compare, flags, interrupt, bus
//
// How it works
// - Crystal divided to 4000Hz by selected ratio
// - 4000Hz divided to 100Hz tick clocking counters
// - Eight cascaded binary 8-bit time counters
// - Unused bits read zero, writes ignore them
// - 51 alarm bits, one word per counter
// - All compared words equal raises alarm event
// - Ignore flag drops a word from compare
// - Six periodic sources, hundredths up to day
// - Fractional division, error averages out per second
// - Periodic and alarm flags raised independently
// - Write-only mask: alarm, then six periodic
// - Flags set on event regardless of mask
// - Status read-only, cleared at read strobe end
// - Flags accumulate; host checks slowest first
// - Global flag set when interrupt output asserts
// - Interrupt needs enable bit and masked flag
// - Status read switches interrupt output off
// - Interrupts keep running on battery standby
// - Power fail disables bus buffers and accesses
// - Backup limits device to timekeeping, interrupts
// - Run bit gates tick to the counters
// - Write-only command: test, irq, run, 24h, crystal
// - Five-bit address map of counters and alarms
// - Alarm word bit 7 is its ignore flag
`timescale 1ns/1ps
`default_nettype none
`include "rtc_cfg.svh"

module rtc_core
  import rtc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       xtal_in,
  input  wire logic       pwr_fail,
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [4:0] addr,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe_n,
  output logic            irq_out,
  output logic            irq_oe_n
);

  // ----------------------------------------------------------------------
  // Pin synchronisation and tick generation
  // ----------------------------------------------------------------------
  localparam rtc_pins_t PIN_RST = '{xtal: 1'b0, pwr_fail: 1'b1,
                                    cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                                    addr: 5'h00, din: 8'h00};

  rtc_pins_t  pin_raw;
  rtc_pins_t  pin;
  rtc_state_t s_q;
  rtc_state_t s_d;
  logic       p100;
  logic       acc_ok;
  logic       rd_now;
  logic       wr_now;
  logic       wr_edge;
  logic       rd_end;
  logic       clear;
  logic       adv;
  logic       c;
  logic       match;
  logic [8:0] r;
  logic [7:0] ev;
  logic [7:0] nf;

  assign pin_raw = '{xtal: xtal_in, pwr_fail: pwr_fail, cs_n: cs_n,
                     rd_n: rd_n, wr_n: wr_n, addr: addr, din: data_in};

  // Strobes and power fail come from outside the clock domain
  rtc_sync #(
    .W   ($bits(rtc_pins_t)),
    .RST (PIN_RST)
  ) u_sync (
    .mclk (mclk),
    .nrst (nrst),
    .d    (pin_raw),
    .q    (pin)
  );

  rtc_prescaler u_pre (
    .mclk  (mclk),
    .nrst  (nrst),
    .xtal  (pin.xtal),
    .fsel  (s_q.cmd[1:0]),
    .test  (s_q.cmd[`RTC_CMD_TEST]),
    .p4000 (),
    .p100  (p100)
  );

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // Valid bits of a counter word; the hour keeps its PM bit
  function automatic logic [7:0] tmask(input logic [2:0] ix);
    unique case (ix)
      `RTC_IX_HUND: tmask = 8'h7F;
      `RTC_IX_HOUR: tmask = 8'h9F;
      `RTC_IX_MIN:  tmask = 8'h3F;
      `RTC_IX_SEC:  tmask = 8'h3F;
      `RTC_IX_MON:  tmask = 8'h0F;
      `RTC_IX_DATE: tmask = 8'h1F;
      `RTC_IX_YEAR: tmask = 8'h7F;
      `RTC_IX_DOW:  tmask = 8'h07;
    endcase
  endfunction : tmask

  // Alarm widths sum to 51 with the ignore bits
  function automatic logic [7:0] amask(input logic [2:0] ix);
    amask = (tmask(ix) & 8'h7F) | 8'h80;
    if (ix == `RTC_IX_HOUR)
      amask = 8'h9F;
  endfunction : amask

  // Step with wrap; carry out in the top bit
  function automatic logic [8:0] step(input logic [7:0] v,
                                      input logic [7:0] lo,
                                      input logic [7:0] hi);
    if (v >= hi)
      step = {1'b1, lo};
    else
      step = {1'b0, v + 8'h01};
  endfunction : step

  // Hour step in either format; carry at midnight
  function automatic logic [8:0] hour_step(input logic [7:0] v,
                                           input logic       h24);
    logic [4:0] h;
    logic       pm;
    h  = v[4:0];
    pm = v[7];
    if (h24)
      hour_step = step({3'b000, h}, 8'h00, 8'h17);
    else if (h == 5'h0B)
      hour_step = {pm, ~pm, 2'b00, 5'h0C};
    else if (h >= 5'h0C)
      hour_step = {1'b0, pm, 2'b00, 5'h01};
    else
      hour_step = {1'b0, pm, 2'b00, h + 5'h01};
  endfunction : hour_step

  // Month length, leap year every fourth year
  function automatic logic [7:0] dim(input logic [7:0] m,
                                     input logic [7:0] y);
    unique case (m)
      8'h02:   dim = (y[1:0] == 2'b00) ? 8'h1D : 8'h1C;
      8'h04, 8'h06, 8'h09, 8'h0B: dim = 8'h1E;
      default: dim = 8'h1F;
    endcase
  endfunction : dim

  // ----------------------------------------------------------------------
  // Alarm compare
  // ----------------------------------------------------------------------
  always_comb
  begin
    match = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      if (!s_q.alm[i][`RTC_ALM_IGN])
        if ((s_q.alm[i] & amask(3'(i)) & 8'h7F & tmask(3'(i))) !=
            (s_q.tm[i] & amask(3'(i)) & 8'h7F & tmask(3'(i))))
          match = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Next state: bus, counters, flags, interrupt
  // ----------------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    r   = 9'h000;
    ev  = 8'h00;
    // Power fail shuts the bus; timekeeping carries on
    acc_ok  = !pin.cs_n && !pin.pwr_fail;
    rd_now  = acc_ok && !pin.rd_n;
    wr_now  = acc_ok && !pin.wr_n && pin.rd_n;
    wr_edge = wr_now && !s_q.acc_wr;
    rd_end  = s_q.acc_rd && !rd_now;
    clear   = rd_end && s_q.rd_stat;
    adv     = p100 && s_q.cmd[`RTC_CMD_RUN];
    c       = adv;
    s_d.acc_rd  = rd_now;
    s_d.acc_wr  = wr_now;
    s_d.rd_stat = rd_now && (s_q.rd_stat || pin.addr == `RTC_A_STATUS);
    s_d.tick    = adv;

    // Counter cascade, one carry per rollover
    if (c)
    begin
      r = step(s_q.tm[`RTC_IX_HUND], 8'h00, 8'h63);
      s_d.tm[`RTC_IX_HUND] = r[7:0];
      c = r[8];
      ev[`RTC_FL_HUND] = 1'b1;
      // Tenths land on every tenth hundredth, so spacing stays even
      ev[`RTC_FL_TENTH] = (s_q.tm[`RTC_IX_HUND] % 8'h0A) == 8'h09;
    end
    if (c)
    begin
      r = step(s_q.tm[`RTC_IX_SEC], 8'h00, 8'h3B);
      s_d.tm[`RTC_IX_SEC] = r[7:0];
      c = r[8];
      ev[`RTC_FL_SEC] = 1'b1;
    end
    if (c)
    begin
      r = step(s_q.tm[`RTC_IX_MIN], 8'h00, 8'h3B);
      s_d.tm[`RTC_IX_MIN] = r[7:0];
      c = r[8];
      ev[`RTC_FL_MIN] = 1'b1;
    end
    if (c)
    begin
      r = hour_step(s_q.tm[`RTC_IX_HOUR], s_q.cmd[`RTC_CMD_H24]);
      s_d.tm[`RTC_IX_HOUR] = r[7:0];
      c = r[8];
      ev[`RTC_FL_HOUR] = 1'b1;
    end
    if (c)
    begin
      r = step(s_q.tm[`RTC_IX_DOW], 8'h00, 8'h06);
      s_d.tm[`RTC_IX_DOW] = r[7:0];
      r = step(s_q.tm[`RTC_IX_DATE], 8'h01,
               dim(s_q.tm[`RTC_IX_MON], s_q.tm[`RTC_IX_YEAR]));
      s_d.tm[`RTC_IX_DATE] = r[7:0];
      c = r[8];
      ev[`RTC_FL_DAY] = 1'b1;
    end
    if (c)
    begin
      r = step(s_q.tm[`RTC_IX_MON], 8'h01, 8'h0C);
      s_d.tm[`RTC_IX_MON] = r[7:0];
      c = r[8];
    end
    if (c)
    begin
      r = step(s_q.tm[`RTC_IX_YEAR], 8'h00, 8'h63);
      s_d.tm[`RTC_IX_YEAR] = r[7:0];
    end

    // Alarm looks at the time one cycle after it moved
    ev[`RTC_FL_ALARM] = s_q.tick && match;

    // Register writes, once per strobe; a write beats a same-cycle tick
    if (wr_edge)
    begin
      if (pin.addr < `RTC_A_ALM_BASE)
        s_d.tm[pin.addr[2:0]] = pin.din & tmask(pin.addr[2:0]);
      else if (pin.addr < `RTC_A_STATUS)
        s_d.alm[pin.addr[2:0]] = pin.din & amask(pin.addr[2:0]);
      else if (pin.addr == `RTC_A_STATUS)
        s_d.mask = pin.din[6:0];
      else if (pin.addr == `RTC_A_CMD)
        s_d.cmd = pin.din[5:0];
    end

    // Sticky flags; a new event outranks the read clear
    nf = (clear ? 8'h00 : s_q.flags) | ev;
    s_d.irq = s_d.cmd[`RTC_CMD_IEN] && |(nf[6:0] & s_d.mask);
    if (s_d.irq)
      nf[`RTC_FL_GLOB] = 1'b1;
    s_d.flags = nf;

    // Read data follows the address while the strobe is held
    s_d.dout = 8'h00;
    if (rd_now)
    begin
      if (pin.addr < `RTC_A_ALM_BASE)
        s_d.dout = s_q.tm[pin.addr[2:0]];
      else if (pin.addr < `RTC_A_STATUS)
        s_d.dout = s_q.alm[pin.addr[2:0]];
      else if (pin.addr == `RTC_A_STATUS)
        s_d.dout = s_q.flags;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q       <= '0;
      s_q.tm    <= {8{`RTC_RST_WORD}};
      s_q.alm   <= {8{`RTC_RST_WORD}};
      s_q.cmd   <= `RTC_RST_CMD;
      s_q.mask  <= `RTC_RST_MASK;
      s_q.flags <= `RTC_RST_FLAGS;
    end
    else
      s_q <= s_d;
  end

  // Open-drain interrupt: pin only ever pulls low
  assign irq_out   = 1'b0;
  assign irq_oe_n  = !s_q.irq;
  assign data_out  = s_q.dout;
  assign data_oe_n = !s_q.acc_rd;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_tick_seen;
    adv ##1 match;
  endsequence

  sequence s_stat_read;
    rd_now && pin.addr == `RTC_A_STATUS ##1 !rd_now;
  endsequence

  AST_RUN_FREEZE: assert property (
    (!s_q.cmd[`RTC_CMD_RUN] && !wr_edge) |=> $stable(s_q.tm))
    else $error("counters moved while stopped");

  AST_HUND_WRAP: assert property (
    (adv && !wr_edge && s_q.tm[`RTC_IX_HUND] == 8'h63)
    |=> s_q.tm[`RTC_IX_HUND] == 8'h00 && s_q.flags[`RTC_FL_SEC])
    else $error("hundredths did not wrap into seconds");

  AST_ALARM_FLAG: assert property (
    s_tick_seen |=> s_q.flags[`RTC_FL_ALARM])
    else $error("alarm match did not set the flag");

  AST_SET_WINS: assert property (
    (clear && adv) |=> s_q.flags[`RTC_FL_HUND])
    else $error("event lost under status clear");

  AST_STAT_CLEAR: assert property (
    (s_stat_read ##0 !adv && !s_q.tick)
    |=> s_q.flags[6:1] == 6'h00)
    else $error("status not cleared by read");

  AST_IRQ_GATE: assert property (
    !irq_oe_n |-> s_q.cmd[`RTC_CMD_IEN] && |(s_q.flags[6:0] & s_q.mask))
    else $error("interrupt without enable and masked flag");

  AST_GLOBAL: assert property (
    !irq_oe_n |-> s_q.flags[`RTC_FL_GLOB])
    else $error("interrupt asserted without global flag");

  AST_IRQ_OFF: assert property (
    (clear && ev == 8'h00) |=> irq_oe_n)
    else $error("interrupt stayed on after status read");

  AST_PF_BUS: assert property (
    pin.pwr_fail |=> data_oe_n && $stable(s_q.cmd) && $stable(s_q.mask))
    else $error("bus active during power fail");

  AST_UNUSED_ZERO: assert property (
    (rd_now && pin.addr > `RTC_A_CMD) |=> data_out == 8'h00)
    else $error("unmapped address read non-zero");

endmodule : rtc_core

`default_nettype wire

// >>> tb/rtc_host_model.sv
// Bus master model of the host processor on the clock's parallel bus
`timescale 1ns/1ps
`default_nettype none

module rtc_host_model (
  input  wire logic       mclk,
  input  wire logic       data_oe_n,
  input  wire logic [7:0] data_out,
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic      [4:0] addr,
  output logic      [7:0] data_in
);
  // ------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------
  // Idle bus: strobes high, no device selected
  initial
  begin
    cs_n    = 1'b1;
    rd_n    = 1'b1;
    wr_n    = 1'b1;
    addr    = 5'h1F;
    data_in = 8'h00;
  end

  // Strobe held past the synchroniser so the write lands once
  task automatic bus_write(input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    cs_n    <= 1'b0;
    wr_n    <= 1'b0;
    addr    <= a;
    data_in <= d;
    repeat (4) @(posedge mclk);
    cs_n    <= 1'b1;
    wr_n    <= 1'b1;
    data_in <= ~d;  // Released bus must not keep a stale value
    repeat (3) @(posedge mclk);
  endtask : bus_write

  // Read; ok stays low when the device never drives the bus
  task automatic bus_read(input logic [4:0] a, output logic [7:0] d,
                          output logic ok);
    int n;
    n  = 0;
    ok = 1'b0;
    d  = 8'h00;
    @(posedge mclk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    addr <= a;
    while (ok !== 1'b1 && n < 8)
    begin
      @(posedge mclk);
      n++;
      if (data_oe_n === 1'b0)
      begin
        ok = 1'b1;
        d  = data_out;
      end
    end
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    n = 0;
    while (data_oe_n !== 1'b1 && n < 8)
    begin
      @(posedge mclk);
      n++;
    end
    repeat (2) @(posedge mclk);
  endtask : bus_read

  // Stop, load one counter, restart at the chosen moment
  task automatic set_counter(input logic [4:0] a, input logic [7:0] v,
                             input logic [7:0] cmd);
    bus_write(5'h11, cmd & 8'hF7);
    bus_write(a, v);
    bus_write(5'h11, cmd);
  endtask : set_counter

endmodule : rtc_host_model
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the clock core
`timescale 1ns/1ps
`default_nettype none

module tb;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  localparam logic [4:0] A_HUND = 5'h00;
  localparam logic [4:0] A_SEC  = 5'h03;
  localparam logic [4:0] A_ST   = 5'h10;
  localparam logic [4:0] A_CMD  = 5'h11;
  localparam logic [7:0] C_STOP = 8'h20;
  localparam logic [7:0] C_RUN  = 8'h28;
  localparam logic [7:0] C_IRQ  = 8'h38;
  logic       mclk;
  logic       nrst;
  logic       xtal_in;
  logic       pwr_fail;
  logic       cs_n;
  logic       rd_n;
  logic       wr_n;
  logic [4:0] addr;
  logic [7:0] data_in;
  logic [7:0] data_out;
  logic       data_oe_n;
  logic       irq_out;
  logic       irq_oe_n;
  logic [7:0] rdat;
  logic       rok;
  int         errors;
  int         samples_checked;

  rtc_core dut (.mclk(mclk), .nrst(nrst), .xtal_in(xtal_in),
    .pwr_fail(pwr_fail), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .irq_out(irq_out), .irq_oe_n(irq_oe_n));

  rtc_host_model host (.mclk(mclk), .data_oe_n(data_oe_n),
    .data_out(data_out), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .addr(addr), .data_in(data_in));

  // 50 MHz system clock
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check8(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : check8

  task automatic check1(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask : check1

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    host.bus_read(a, rdat, rok);
    check1("bus answer", 1'b1, rok);
    check8($sformatf("register %h", a), e, rdat);
  endtask : rd_chk

  // Test mode: one tick per crystal pulse, so counts are exact
  task automatic pulses(input int n);
    repeat (n)
    begin
      @(posedge mclk);
      xtal_in <= 1'b1;
      repeat (4) @(posedge mclk);
      xtal_in <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    repeat (10) @(posedge mclk);
  endtask : pulses

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rd_chk(A_ST, 8'h00);
    rd_chk(A_CMD, 8'h00);
    rd_chk(5'h12, 8'h00);
  endtask : t_reset

  // Normal mode from reset: 40 steps of 4000Hz need 328 crystal edges
  task automatic t_div;
    host.bus_write(A_CMD, 8'h08);
    pulses(327);
    rd_chk(A_HUND, 8'h00);
    pulses(1);
    rd_chk(A_HUND, 8'h01);
  endtask : t_div

  // Every counter and alarm word written all-ones; only its own bits survive
  task automatic t_fields;
    logic [7:0] lim [16] = '{8'h7F, 8'h9F, 8'h3F, 8'h3F, 8'h0F, 8'h1F,
      8'h7F, 8'h07, 8'hFF, 8'h9F, 8'hBF, 8'hBF, 8'h8F, 8'h9F, 8'hFF,
      8'h87};
    for (int i = 0; i < 16; i++)
    begin
      host.bus_write(5'(i), 8'hFF);
      rd_chk(5'(i), lim[i]);
    end
    host.bus_write(5'h1F, 8'hFF);
    rd_chk(5'h1F, 8'h00);
    for (int i = 0; i < 16; i++)
      host.bus_write(5'(i), 8'h00);
    // Day alarm never met in this run, so no stray alarm flags
    host.bus_write(5'h0F, 8'h06);
  endtask : t_fields

  task automatic t_run;
    host.bus_write(A_CMD, C_STOP);
    pulses(3);
    rd_chk(A_HUND, 8'h00);
    host.bus_write(A_CMD, C_RUN);
    pulses(3);
    rd_chk(A_HUND, 8'h03);
  endtask : t_run

  task automatic t_flags;
    host.bus_read(A_ST, rdat, rok);
    host.set_counter(A_HUND, 8'h5F, C_RUN);
    pulses(5);
    check1("irq pin", 1'b1, irq_oe_n);
    rd_chk(A_ST, 8'h0E);
    rd_chk(A_ST, 8'h00);
    rd_chk(A_SEC, 8'h01);
  endtask : t_flags

  task automatic t_irq;
    host.bus_write(A_ST, 8'h08);
    host.set_counter(A_HUND, 8'h63, C_RUN);
    pulses(1);
    check1("irq pin", 1'b1, irq_oe_n);
    rd_chk(A_ST, 8'h0E);
    host.set_counter(A_HUND, 8'h63, C_IRQ);
    pulses(1);
    check1("irq pin", 1'b0, irq_oe_n);
    check1("irq level", 1'b0, irq_out);
    rd_chk(A_ST, 8'h8E);
    check1("irq pin", 1'b1, irq_oe_n);
    host.set_counter(A_HUND, 8'h63, C_IRQ);
    @(posedge mclk);
    pwr_fail <= 1'b1;
    repeat (4) @(posedge mclk);
    host.bus_write(5'h02, 8'h2A);
    host.bus_read(A_ST, rdat, rok);
    check1("bus answer", 1'b0, rok);
    pulses(1);
    check1("irq pin", 1'b0, irq_oe_n);
    @(posedge mclk);
    pwr_fail <= 1'b0;
    repeat (4) @(posedge mclk);
    rd_chk(5'h02, 8'h00);
    rd_chk(A_ST, 8'h8E);
  endtask : t_irq

  task automatic t_alarm;
    host.bus_write(A_ST, 8'h01);
    host.bus_write(A_CMD, C_STOP);
    for (int i = 9; i < 16; i++)
      host.bus_write(5'(i), 8'h80);
    host.bus_write(5'h08, 8'h05);
    host.bus_write(5'h0B, 8'h07);
    host.bus_write(A_SEC, 8'h02);
    host.set_counter(A_HUND, 8'h03, C_IRQ);
    pulses(2);
    rd_chk(A_ST, 8'h02);
    host.bus_write(5'h0B, 8'h87);
    host.set_counter(A_HUND, 8'h03, C_IRQ);
    pulses(2);
    check1("irq pin", 1'b0, irq_oe_n);
    rd_chk(A_ST, 8'h83);
  endtask : t_alarm

  // 24-hour mode: one tick rolls every counter over at once
  task automatic t_wrap;
    logic [7:0] top [8] = '{8'h63, 8'h17, 8'h3B, 8'h3B, 8'h0C, 8'h1F,
      8'h63, 8'h06};
    logic [7:0] bot [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01,
      8'h00, 8'h00};
    host.bus_write(A_CMD, 8'h24);
    for (int i = 0; i < 8; i++)
      host.bus_write(5'(i), top[i]);
    host.bus_write(A_CMD, 8'h2C);
    pulses(1);
    for (int i = 0; i < 8; i++)
      rd_chk(5'(i), bot[i]);
    rd_chk(A_ST, 8'h7E);
  endtask : t_wrap

  // ------------------------------------------------------------
  // Run
  // ------------------------------------------------------------
  task automatic report_and_stop;
    if (errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // Main sequence after a three-cycle reset
  initial
  begin
    nrst            = 1'b0;
    xtal_in         = 1'b0;
    pwr_fail        = 1'b0;
    errors          = 0;
    samples_checked = 0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    t_reset;
    t_div;
    t_fields;
    t_run;
    t_flags;
    t_irq;
    t_alarm;
    t_wrap;
    report_and_stop;
  end

  // Watchdog: run needs a few thousand cycles, allow ten times that
  initial
  begin
    repeat (40000) @(posedge mclk);
    errors++;
    report_and_stop;
  end

endmodule : tb
`default_nettype wire
